/* cmed_pkg.sv */
package cmed_pkg;

   // ----------------------------------------
   // Parameter addresses (command codes)
   // ----------------------------------------
   localparam logic [7:0] ADDR_LEAD = 8'h04;
   localparam logic [7:0] ADDR_TRAIL = 8'h05;
   localparam logic [7:0] ADDR_SEQ = 8'h13;
   localparam logic [7:0] ADDR_SEL = 8'h28;
   localparam logic [7:0] ADDR_BKEN = 8'h2d;
   localparam logic [7:0] ADDR_BRKTO = 8'h2f;

   // ----------------------------------------
   // Reset values and legal ranges
   // ----------------------------------------
   localparam logic [15:0] RST_LEAD = 16'h000a;
   localparam logic [15:0] RST_TRAIL = 16'h000a;
   localparam logic [7:0] RST_SEQ = 8'h2d;
   localparam logic [7:0] RST_SEL = 8'h00;
   localparam logic [15:0] RST_BRKTO = 16'h0000;
   localparam logic RST_BKEN = 1'b0;
   localparam logic [15:0] LEAD_BAD = 16'h0001;
   localparam logic [7:0] SEQ_MIN = 8'h20;
   localparam logic [7:0] SEQ_MAX = 8'h7f;
   localparam logic [7:0] SEL_MAX = 8'h04;
   localparam logic [15:0] BKEN_MAX = 16'h0001;

   // ----------------------------------------
   // Output line selector codes
   // ----------------------------------------
   localparam logic [7:0] SEL_RXIND = 8'h00;
   localparam logic [7:0] SEL_HIGH = 8'h01;
   localparam logic [7:0] SEL_LOW = 8'h02;
   localparam logic [7:0] SEL_PKT = 8'h04;

   // ----------------------------------------
   // Read lengths in bytes
   // ----------------------------------------
   localparam logic [1:0] LEN_WORD = 2'h2;
   localparam logic [1:0] LEN_BYTE = 2'h1;
   localparam logic [1:0] LEN_NONE = 2'h0;

   // ----------------------------------------
   // Timing
   // ----------------------------------------
   localparam int unsigned CLK_HZ = 10_000_000;
   localparam int unsigned UNIT_MS = 100;
   localparam int unsigned SEC_MS = 1000;
   localparam int unsigned FAST_GUARD_MS = 600;
   localparam int unsigned TICK_CYC = CLK_HZ / 1000 * UNIT_MS;
   localparam int unsigned SEC_CYC = CLK_HZ / 1000 * SEC_MS;
   localparam logic [15:0] FAST_GUARD = 16'(FAST_GUARD_MS / UNIT_MS);
   localparam logic [1:0] SEQ_COUNT = 2'h3;

   typedef enum logic [1:0] {
      ST_QUIET = 2'b00,
      ST_SEQ = 2'b01,
      ST_TRAIL = 2'b11,
      ST_CMD = 2'b10
   } cmed_state_t;

endpackage : cmed_pkg

/* cmed_tick.sv */
`timescale 1ns/10ps

module cmed_tick #(
   parameter int unsigned PERIOD = 1000
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Restart the period
   input wire logic clr,
   // One-cycle pulse per period
   output logic tick_q
);

   typedef struct packed {
      logic [23:0] cnt;
      logic tick;
   } cmed_tick_t;

   localparam logic [23:0] LAST = 24'(PERIOD - 1);

   cmed_tick_t q;
   cmed_tick_t d;

   always_comb
   begin
      d = q;
      d.tick = 1'b0;
      if (clr)
      begin
         d.cnt = '0;
      end
      else if (q.cnt == LAST)
      begin
         d.cnt = '0;
         d.tick = 1'b1;
      end
      else
      begin
         d.cnt = q.cnt + 24'h000001;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= '0;
      end
      else
      begin
         q <= d;
      end
   end

   assign tick_q = q.tick;

endmodule : cmed_tick

/* cmed_top.sv */
`timescale 1ns/10ps

// Summary of operation
// - Leading silence guard is a writable 16-bit count of 100 ms units, default 0x0a.
// - Command mode is entered only after lead silence, the sequence characters, then trail silence.
// - Default pattern is 1 s silence, three sequence characters, 1 s silence; guards and character programmable, count fixed at three.
// - Sequence character accepts writes 0x20 to 0x7f only and resets to 0x2d.
// - With both guard settings zero, both guards last 0.6 s.
// - With break passing on, output break is released after the break timeout in seconds.
// - Third digital output follows the selector: rx indicator, high, low, reserved, packet sent.
// - Reads return 2 bytes for lead guard and break timeout, 1 byte for character and selector.
// - Trailing silence guard is a writable count of 100 ms units, default 0x0a.
// - Break passing enable set to 1 forwards an input break to the far modem, 0 blocks it.

module cmed_top #(
   parameter int unsigned TICK_CYC = cmed_pkg::TICK_CYC,
   parameter int unsigned SEC_CYC = cmed_pkg::SEC_CYC
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic sys_rst,
   // Serial input characters
   input wire logic rx_valid,
   input wire logic [7:0] rx_char,
   output logic rx_ready_q,
   // Characters passed on as data
   output logic fwd_valid_q,
   output logic [7:0] fwd_char_q,
   // Command mode
   input wire logic cmd_exit,
   output logic cmd_mode_q,
   // Parameter access
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [15:0] cfg_wdata,
   output logic cfg_rvalid_q,
   output logic [15:0] cfg_rdata_q,
   output logic [1:0] cfg_rbytes_q,
   output logic cfg_err_q,
   // Serial break
   input wire logic brk_in,
   input wire logic brk_status,
   output logic brk_send_q,
   output logic dout_brk_q,
   // Third digital output
   input wire logic receive_indicator,
   input wire logic pkt_sent,
   output logic third_digital_output_q
);

   typedef struct packed {
      cmed_pkg::cmed_state_t st;
      logic [15:0] sil;
      logic [1:0] hold;
      logic [1:0] flush;
      logic pend_v;
      logic [7:0] pend_c;
      logic rdy;
      logic cmd;
      logic [15:0] lead;
      logic [15:0] trail;
      logic [7:0] seq;
      logic [7:0] sel;
      logic [15:0] brk_to;
      logic bk_en;
      logic [15:0] brk_sec;
      logic brk_out;
      logic brk_fwd;
      logic do3;
      logic ov;
      logic [7:0] oc;
      logic rv;
      logic [15:0] rd;
      logic [1:0] rb;
      logic rerr;
   } cmed_q_t;

   // ----------------------------------------
   // Reset image
   // ----------------------------------------
   localparam cmed_q_t Q_RST = '{
      st: cmed_pkg::ST_QUIET,
      sil: '0,
      hold: '0,
      flush: '0,
      pend_v: 1'b0,
      pend_c: '0,
      rdy: 1'b1,
      cmd: 1'b0,
      lead: cmed_pkg::RST_LEAD,
      trail: cmed_pkg::RST_TRAIL,
      seq: cmed_pkg::RST_SEQ,
      sel: cmed_pkg::RST_SEL,
      brk_to: cmed_pkg::RST_BRKTO,
      bk_en: cmed_pkg::RST_BKEN,
      brk_sec: '0,
      brk_out: 1'b0,
      brk_fwd: 1'b0,
      do3: 1'b0,
      ov: 1'b0,
      oc: '0,
      rv: 1'b0,
      rd: '0,
      rb: '0,
      rerr: 1'b0
   };

   function automatic logic [15:0] guard_need(input logic [15:0] mine, input logic [15:0] other);
      if (mine == 16'h0000 && other == 16'h0000)
      begin
         return cmed_pkg::FAST_GUARD;
      end
      return mine;
   endfunction : guard_need

   cmed_q_t q;
   cmed_q_t d;
   logic take;
   logic gtick;
   logic btick;
   logic [15:0] lead_need;
   logic [15:0] trail_need;

   assign take = rx_valid & q.rdy;
   assign lead_need = guard_need(q.lead, q.trail);
   assign trail_need = guard_need(q.trail, q.lead);

   // ----------------------------------------
   // Time bases
   // ----------------------------------------
   // Restarted by each character, so silence is measured from the character itself
   cmed_tick #(.PERIOD(TICK_CYC)) u_guard_tick (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clr(take),
      .tick_q(gtick)
   );

   cmed_tick #(.PERIOD(SEC_CYC)) u_brk_tick (
      .mclk(mclk),
      .sys_rst(sys_rst),
      .clr(brk_status),
      .tick_q(btick)
   );

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb
   begin
      d = q;
      d.ov = 1'b0;
      d.rv = 1'b0;
      d.rerr = 1'b0;
      d.brk_fwd = brk_in & q.bk_en;
      if (gtick && q.sil != 16'hffff)
      begin
         d.sil = q.sil + 16'h0001;
      end
      if (take)
      begin
         d.sil = '0;
      end
      // Replay of held characters after an abandoned pattern
      if (q.flush != 2'h0)
      begin
         d.ov = 1'b1;
         d.oc = q.seq;
         d.flush = q.flush - 2'h1;
      end
      else if (q.pend_v)
      begin
         d.ov = 1'b1;
         d.oc = q.pend_c;
         d.pend_v = 1'b0;
      end
      case (q.st)
         cmed_pkg::ST_QUIET:
         begin
            if (take && q.sil >= lead_need && rx_char == q.seq)
            begin
               d.hold = 2'h1;
               d.st = cmed_pkg::ST_SEQ;
            end
            else if (take)
            begin
               d.ov = 1'b1;
               d.oc = rx_char;
            end
         end
         cmed_pkg::ST_SEQ:
         begin
            if (take && rx_char == q.seq)
            begin
               d.hold = q.hold + 2'h1;
               if (q.hold == cmed_pkg::SEQ_COUNT - 2'h1)
               begin
                  d.st = cmed_pkg::ST_TRAIL;
               end
            end
            else if (take || q.sil >= lead_need)
            begin
               // Typing slower than the guard also abandons the pattern
               d.flush = q.hold;
               d.hold = '0;
               d.pend_v = take;
               d.pend_c = rx_char;
               d.st = cmed_pkg::ST_QUIET;
            end
         end
         cmed_pkg::ST_TRAIL:
         begin
            if (take)
            begin
               d.flush = q.hold;
               d.hold = '0;
               d.pend_v = 1'b1;
               d.pend_c = rx_char;
               d.st = cmed_pkg::ST_QUIET;
            end
            else if (q.sil >= trail_need)
            begin
               d.hold = '0;
               d.st = cmed_pkg::ST_CMD;
            end
         end
         cmed_pkg::ST_CMD:
         begin
            if (take)
            begin
               d.ov = 1'b1;
               d.oc = rx_char;
            end
            if (cmd_exit)
            begin
               d.st = cmed_pkg::ST_QUIET;
            end
         end
         default:
         begin
            d.st = cmed_pkg::ST_QUIET;
         end
      endcase
      d.cmd = (d.st == cmed_pkg::ST_CMD);
      d.rdy = (d.flush == 2'h0) && !d.pend_v;

      // Parameter writes; out-of-range values are refused and flagged
      if (cfg_wr)
      begin
         case (cfg_addr)
            cmed_pkg::ADDR_LEAD:
            begin
               if (cfg_wdata != cmed_pkg::LEAD_BAD)
               begin
                  d.lead = cfg_wdata;
               end
               else
               begin
                  d.rerr = 1'b1;
               end
            end
            cmed_pkg::ADDR_TRAIL:
            begin
               d.trail = cfg_wdata;
            end
            cmed_pkg::ADDR_SEQ:
            begin
               if (cfg_wdata[15:8] == 8'h00 && cfg_wdata[7:0] >= cmed_pkg::SEQ_MIN
                   && cfg_wdata[7:0] <= cmed_pkg::SEQ_MAX)
               begin
                  d.seq = cfg_wdata[7:0];
               end
               else
               begin
                  d.rerr = 1'b1;
               end
            end
            cmed_pkg::ADDR_SEL:
            begin
               if (cfg_wdata <= {8'h00, cmed_pkg::SEL_MAX})
               begin
                  d.sel = cfg_wdata[7:0];
               end
               else
               begin
                  d.rerr = 1'b1;
               end
            end
            cmed_pkg::ADDR_BKEN:
            begin
               if (cfg_wdata <= cmed_pkg::BKEN_MAX)
               begin
                  d.bk_en = cfg_wdata[0];
               end
               else
               begin
                  d.rerr = 1'b1;
               end
            end
            cmed_pkg::ADDR_BRKTO:
            begin
               d.brk_to = cfg_wdata;
            end
            default:
            begin
               d.rerr = 1'b1;
            end
         endcase
      end
      else if (cfg_rd)
      begin
         d.rv = 1'b1;
         d.rd = '0;
         d.rb = cmed_pkg::LEN_BYTE;
         case (cfg_addr)
            cmed_pkg::ADDR_LEAD:
            begin
               d.rd = q.lead;
               d.rb = cmed_pkg::LEN_WORD;
            end
            cmed_pkg::ADDR_TRAIL:
            begin
               d.rd = q.trail;
               d.rb = cmed_pkg::LEN_WORD;
            end
            cmed_pkg::ADDR_SEQ:
            begin
               d.rd = {8'h00, q.seq};
            end
            cmed_pkg::ADDR_SEL:
            begin
               d.rd = {8'h00, q.sel};
            end
            cmed_pkg::ADDR_BKEN:
            begin
               d.rd = {15'h0000, q.bk_en};
            end
            cmed_pkg::ADDR_BRKTO:
            begin
               d.rd = q.brk_to;
               d.rb = cmed_pkg::LEN_WORD;
            end
            default:
            begin
               d.rb = cmed_pkg::LEN_NONE;
               d.rerr = 1'b1;
            end
         endcase
      end

      // Output break hold; fresh status wins over the timeout
      if (btick && q.brk_sec != 16'hffff)
      begin
         d.brk_sec = q.brk_sec + 16'h0001;
      end
      if (brk_status && q.bk_en)
      begin
         d.brk_out = 1'b1;
         d.brk_sec = '0;
      end
      else if (brk_status)
      begin
         d.brk_sec = '0;
      end
      else if (q.brk_out && (q.brk_sec >= q.brk_to || !q.bk_en))
      begin
         d.brk_out = 1'b0;
      end

      case (q.sel)
         cmed_pkg::SEL_RXIND: d.do3 = receive_indicator;
         cmed_pkg::SEL_HIGH: d.do3 = 1'b1;
         cmed_pkg::SEL_LOW: d.do3 = 1'b0;
         cmed_pkg::SEL_PKT: d.do3 = pkt_sent;
         default: d.do3 = 1'b0;
      endcase
   end

   always_ff @(posedge mclk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         q <= Q_RST;
      end
      else
      begin
         q <= d;
      end
   end

   assign rx_ready_q = q.rdy;
   assign fwd_valid_q = q.ov;
   assign fwd_char_q = q.oc;
   assign cmd_mode_q = q.cmd;
   assign cfg_rvalid_q = q.rv;
   assign cfg_rdata_q = q.rd;
   assign cfg_rbytes_q = q.rb;
   assign cfg_err_q = q.rerr;
   assign brk_send_q = q.brk_fwd;
   assign dout_brk_q = q.brk_out;
   assign third_digital_output_q = q.do3;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   seq_start_a: assert property (
      q.st == cmed_pkg::ST_QUIET && take && q.sil >= lead_need && rx_char == q.seq
      |=> q.st == cmed_pkg::ST_SEQ && q.hold == 2'h1 && !fwd_valid_q)
      else $error("sequence start not taken after lead guard");

   cmd_entry_a: assert property (
      q.st == cmed_pkg::ST_TRAIL && !take && q.sil >= trail_need
      |=> cmd_mode_q && q.hold == 2'h0)
      else $error("command mode not entered after trail guard");

   abort_flush_a: assert property (
      q.st == cmed_pkg::ST_TRAIL && take
      |=> q.flush == cmed_pkg::SEQ_COUNT && q.pend_v && !rx_ready_q ##1 fwd_valid_q)
      else $error("abandoned pattern not replayed");

   seq_range_a: assert property (
      cfg_wr && cfg_addr == cmed_pkg::ADDR_SEQ && cfg_wdata < {8'h00, cmed_pkg::SEQ_MIN}
      |=> $stable(q.seq) && cfg_err_q)
      else $error("out of range sequence character stored");

   fast_guard_a: assert property (
      q.lead == 16'h0000 && q.trail == 16'h0000
      |-> lead_need == cmed_pkg::FAST_GUARD && trail_need == cmed_pkg::FAST_GUARD)
      else $error("fast guard not applied");

   brk_release_a: assert property (
      dout_brk_q && !brk_status && q.brk_sec >= q.brk_to |=> !dout_brk_q)
      else $error("output break held past timeout");

   do3_select_a: assert property (
      q.sel == cmed_pkg::SEL_LOW ##1 q.sel == cmed_pkg::SEL_LOW |-> !third_digital_output_q)
      else $error("third output not low when selected low");

   read_len_a: assert property (
      !cfg_wr && cfg_rd && cfg_addr == cmed_pkg::ADDR_BRKTO
      |=> cfg_rvalid_q && cfg_rbytes_q == cmed_pkg::LEN_WORD && cfg_rdata_q == $past(q.brk_to))
      else $error("break timeout read length wrong");

   brk_pass_a: assert property (
      brk_in && !q.bk_en |=> !brk_send_q)
      else $error("break forwarded while disabled");

   cmd_hold_a: assert property (
      cmd_mode_q && !cmd_exit |=> cmd_mode_q)
      else $error("command mode left without exit");

endmodule : cmed_top

/* cmed_host.sv */
`timescale 1ns/10ps

// ----------------------------------------
// Host terminal on the serial input
// ----------------------------------------
module cmed_host (
   // Clock
   input wire logic mclk,
   // Character handshake
   input wire logic rx_ready_q,
   output logic rx_valid,
   output logic [7:0] rx_char
);
   initial
   begin
      rx_valid = 1'b0;
      rx_char = 8'h00;
   end

   // Silence of gap cycles, then one character held until taken
   task automatic send(input logic [7:0] c, input int gap);
      logic ok;
      repeat (gap)
      begin
         @(posedge mclk);
         #1;
      end
      rx_valid = 1'b1;
      rx_char = c;
      do
      begin
         ok = rx_ready_q;
         @(posedge mclk);
      end while (!ok);
      #1;
      rx_valid = 1'b0;
      // Stale character must not look valid
      rx_char = ~c;
   endtask : send
endmodule : cmed_host

/* tb_command_mode_entry_detector.sv */
`timescale 1ns/10ps

module tb_command_mode_entry_detector;
   localparam int unsigned TICK = 10;
   localparam int unsigned SEC = 20;
   logic mclk, sys_rst, rx_valid, rx_ready_q, fwd_valid_q, cmd_exit, cmd_mode_q;
   logic [7:0] rx_char, fwd_char_q, cfg_addr, c;
   logic cfg_wr, cfg_rd, cfg_rvalid_q, cfg_err_q, brk_in, brk_status, brk_send_q, dout_brk_q;
   logic [15:0] cfg_wdata, cfg_rdata_q;
   logic [1:0] cfg_rbytes_q;
   logic receive_indicator, pkt_sent, third_digital_output_q, e;
   int error_cnt = 0;
   int samples_checked = 0;
   int seed = 694;
   int cycles = 0;
   int mdl[int];
   logic [7:0] got_q[$], exp_q[$];
   logic [7:0] ta[11] = '{8'h04, 8'h04, 8'h13, 8'h13, 8'h13, 8'h13, 8'h28, 8'h28, 8'h2d,
                          8'h10, 8'h05};
   logic [15:0] td[11] = '{16'h1, 16'h2, 16'h1f, 16'h20, 16'h7f, 16'h80, 16'h5, 16'h4,
                           16'h2, 16'h5, 16'hffff};
   logic [7:0] codes[6] = '{8'h04, 8'h05, 8'h13, 8'h28, 8'h2d, 8'h2f};

   cmed_top #(.TICK_CYC(TICK), .SEC_CYC(SEC)) u_cmed_top (
      .mclk(mclk), .sys_rst(sys_rst), .rx_valid(rx_valid), .rx_char(rx_char),
      .rx_ready_q(rx_ready_q), .fwd_valid_q(fwd_valid_q), .fwd_char_q(fwd_char_q),
      .cmd_exit(cmd_exit), .cmd_mode_q(cmd_mode_q), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rvalid_q(cfg_rvalid_q),
      .cfg_rdata_q(cfg_rdata_q), .cfg_rbytes_q(cfg_rbytes_q), .cfg_err_q(cfg_err_q),
      .brk_in(brk_in), .brk_status(brk_status), .brk_send_q(brk_send_q),
      .dout_brk_q(dout_brk_q), .receive_indicator(receive_indicator), .pkt_sent(pkt_sent),
      .third_digital_output_q(third_digital_output_q));

   cmed_host u_cmed_host (.mclk(mclk), .rx_ready_q(rx_ready_q), .rx_valid(rx_valid),
      .rx_char(rx_char));

   initial
   begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   // ----------------------------------------
   // Watchdog and forwarded character capture
   // ----------------------------------------
   always @(posedge mclk)
   begin
      cycles++;
      if (cycles > 20000)
      begin
         error_cnt++;
         close_out();
      end
   end

   always @(negedge mclk)
      if (fwd_valid_q === 1'b1) got_q.push_back(fwd_char_q);

   // ----------------------------------------
   // Reference model and checks
   // ----------------------------------------
   function automatic void mdl_rst();
      mdl.delete();
      mdl[8'h04] = 16'h0a;
      mdl[8'h05] = 16'h0a;
      mdl[8'h13] = 16'h2d;
      mdl[8'h28] = 0;
      mdl[8'h2d] = 0;
      mdl[8'h2f] = 0;
   endfunction : mdl_rst

   function automatic bit acc(int a, int d);
      case (a)
         8'h04: return d != 1;
         8'h13: return d >= 8'h20 && d <= 8'h7f;
         8'h28: return d <= 4;
         8'h2d: return d <= 1;
         8'h05, 8'h2f: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction : acc

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      samples_checked++;
      if (got !== exp)
      begin
         error_cnt++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp

   task automatic chk_lvl(input logic got, input logic exp);
      cmp({15'h0, got}, {15'h0, exp});
   endtask : chk_lvl

   task automatic chk_fwd();
      cmp(16'(got_q.size()), 16'(exp_q.size()));
      while (got_q.size() > 0 && exp_q.size() > 0) cmp(got_q.pop_front(), exp_q.pop_front());
      got_q.delete();
      exp_q.delete();
   endtask : chk_fwd

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : cyc

   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      logic ok;
      ok = acc(a, d);
      cfg_wr = 1'b1;
      cfg_addr = a;
      cfg_wdata = d;
      cyc(1);
      cfg_wr = 1'b0;
      chk_lvl(cfg_err_q, !ok);
      if (ok) mdl[a] = d;
      cyc(1);
   endtask : wr

   task automatic chk_rd(input logic [7:0] a);
      cfg_rd = 1'b1;
      cfg_addr = a;
      cyc(1);
      cfg_rd = 1'b0;
      chk_lvl(cfg_err_q, !mdl.exists(a));
      if (mdl.exists(a))
      begin
         chk_lvl(cfg_rvalid_q, 1'b1);
         cmp(cfg_rdata_q, 16'(mdl[a]));
         cmp(cfg_rbytes_q, 16'((a == 8'h04 || a == 8'h05 || a == 8'h2f) ? 2 : 1));
      end
      else
      begin
         cmp(cfg_rbytes_q, 16'h0000);
      end
      cyc(1);
   endtask : chk_rd

   task automatic seq3(input logic [7:0] ch, input int lead);
      u_cmed_host.send(ch, lead);
      u_cmed_host.send(ch, 1);
      u_cmed_host.send(ch, 1);
   endtask : seq3

   task automatic leave();
      cmd_exit = 1'b1;
      cyc(1);
      cmd_exit = 1'b0;
      cyc(1);
      chk_lvl(cmd_mode_q, 1'b0);
   endtask : leave

   task automatic close_out();
      if (error_cnt == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : close_out

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      {sys_rst, cmd_exit, cfg_wr, cfg_rd, brk_in, brk_status} = 6'b100000;
      {receive_indicator, pkt_sent, cfg_addr, cfg_wdata} = '0;
      mdl_rst();
      cyc(3);
      sys_rst = 1'b0;
      chk_lvl(rx_ready_q, 1'b1);
      foreach (mdl[a]) chk_rd(8'(a));
      chk_rd(8'h10);
      // Default pattern, trailing guard not cut short
      seq3(8'h2d, 130);
      cyc(80);
      chk_lvl(cmd_mode_q, 1'b0);
      cyc(50);
      chk_lvl(cmd_mode_q, 1'b1);
      u_cmed_host.send(8'h41, 1);
      exp_q.push_back(8'h41);
      cyc(3);
      chk_fwd();
      chk_lvl(cmd_mode_q, 1'b1);
      leave();
      // Wrong character during the trailing guard
      seq3(8'h2d, 130);
      u_cmed_host.send(8'h58, 20);
      chk_lvl(rx_ready_q, 1'b0);
      cyc(150);
      chk_lvl(cmd_mode_q, 1'b0);
      exp_q = '{8'h2d, 8'h2d, 8'h2d, 8'h58};
      chk_fwd();
      // Leading guard broken by earlier activity
      u_cmed_host.send(8'h61, 1);
      seq3(8'h2d, 30);
      cyc(150);
      chk_lvl(cmd_mode_q, 1'b0);
      exp_q = '{8'h61, 8'h2d, 8'h2d, 8'h2d};
      chk_fwd();
      // Fast guards with a random sequence character
      c = 8'h20 + (8'($random(seed)) & 8'h5f);
      wr(8'h04, 16'h0);
      wr(8'h05, 16'h0);
      wr(8'h13, {8'h0, c});
      seq3(c, 75);
      cyc(45);
      chk_lvl(cmd_mode_q, 1'b0);
      cyc(35);
      chk_lvl(cmd_mode_q, 1'b1);
      leave();
      chk_fwd();
      // Third output for every selector code
      for (int s = 0; s < 5; s++)
      begin
         wr(8'h28, 16'(s));
         repeat (4)
         begin
            receive_indicator = $random(seed);
            pkt_sent = $random(seed);
            cyc(2);
            e = (s == 0) ? receive_indicator : (s == 1) ? 1'b1 : (s == 4) ? pkt_sent : 1'b0;
            chk_lvl(third_digital_output_q, e);
         end
      end
      // Break forwarding and release
      brk_in = 1'b1;
      cyc(2);
      chk_lvl(brk_send_q, 1'b0);
      wr(8'h2d, 16'h1);
      chk_lvl(brk_send_q, 1'b1);
      brk_in = 1'b0;
      wr(8'h2f, 16'h1);
      brk_status = 1'b1;
      cyc(1);
      brk_status = 1'b0;
      cyc(2);
      chk_lvl(dout_brk_q, 1'b1);
      cyc(9);
      chk_lvl(dout_brk_q, 1'b1);
      cyc(40);
      chk_lvl(dout_brk_q, 1'b0);
      wr(8'h2f, 16'h0);
      brk_status = 1'b1;
      cyc(2);
      chk_lvl(dout_brk_q, 1'b1);
      brk_status = 1'b0;
      cyc(3);
      chk_lvl(dout_brk_q, 1'b0);
      // Long timeout, so only clearing the enable can release the pin
      wr(8'h2f, 16'h0010);
      brk_status = 1'b1;
      cyc(2);
      brk_status = 1'b0;
      chk_lvl(dout_brk_q, 1'b1);
      wr(8'h2d, 16'h0);
      chk_lvl(dout_brk_q, 1'b0);
      // Range edges, unknown code, then random writes
      foreach (ta[i])
      begin
         wr(ta[i], td[i]);
         chk_rd(ta[i]);
      end
      repeat (12)
      begin
         c = codes[($random(seed) & 32'h7fffffff) % 6];
         cfg_wdata = $random(seed);
         if (c == 8'h13 || c == 8'h28 || c == 8'h2d) cfg_wdata[15:8] = 8'h00;
         wr(c, cfg_wdata);
         chk_rd(c);
      end
      // Second reset restores every setting
      sys_rst = 1'b1;
      cyc(2);
      sys_rst = 1'b0;
      mdl_rst();
      foreach (mdl[a]) chk_rd(8'(a));
      close_out();
   end
endmodule : tb_command_mode_entry_detector
